// file: ext_config_dram_debug_sig_regs.v
// Purpose: Extended config registers: DRAM timing, memory map, debug mux, signature control
// Assumes: Host index/data access is synchronous to CLOCK_I (the memory clock)
// Notes:   Timing runs in whole-clock steps; the d delay is shown as a separate qualifier
//
// Operation
// [R1] Zero-wait output low per select code
// [R2] Software never programs zero-wait code 00
// [R3] CAS shaping: two clocks, low width per code
// [R4] CAS starts 2.5 or 1.5 clocks after RAS (code: 3 or 2 clocks)
// [R5] RAS precharge width selected by two bits
// [R6] Claim memory when nibble matches address 23:20
// [R7] Expansion ROM decodes at nibble zero only
// [R8] Mapping nibble clears on reset
// [R9] Debug mux needs pin config bits 5,3
// [R10] Debug output one selector functions
// [R11] Debug output zero selector functions
// [R12] Signature control needs unlock value 48h
// [R13] Software writes zero to upper control bits
// [R14] Start bit rising begins one-frame signature
// [R15] Initialize zero preloads signature 0001h
// [R16] Test pattern feeds zeros to analyzer
// [R17] Timing changes apply at access boundary
`timescale 1ns/10ps
`include "ext_cfg_map.vh"
module ext_config_dram_debug_sig_regs (
    input wire CLOCK_I, // Memory clock, 50 MHz
    input wire RESET_I, // Synchronous reset, active high
    input wire [7:0] INDEX_I, // Register index
    input wire [7:0] WDATA_I, // Write data
    input wire WRITE_I, // Register write strobe
    input wire [7:0] UNLOCK_KEY_I, // Current unlock_key_reg value
    input wire [7:0] PIN_CONFIG_I, // Current pin_config_reg value
    input wire WBUF_READY_I, // Write buffer ready
    input wire WBUF_EMPTY_I, // Write buffer empty
    input wire WBUF_CYCLE_I, // Write buffer cycle active
    input wire MEM_DECODED_I, // Memory address decoded
    input wire MEM_WRITE_STROBE_N_I, // Memory write strobe, active low
    input wire IO_WRITE_I, // I/O write to device in progress
    input wire IO_DECODED_I, // I/O address decoded
    input wire CPU_READ_I, // CPU read cycle
    input wire CPU_WRITE_I, // CPU write cycle
    input wire WRITE_BYPASS_I, // CPU write not through write buffer
    input wire FONT_FETCH_I, // Font fetch
    input wire GFX_FETCH_I, // Graphics fetch
    input wire ATTR_FETCH_I, // Attribute fetch
    input wire [3:0] HOST_ADDR_UPPER_NIBBLE_I, // Host address 23:20
    input wire MEM_ACCESS_I, // Host memory cycle in display range
    input wire ROM_ACCESS_I, // Host cycle in expansion ROM range
    input wire DRAM_REQ_I, // DRAM access request
    input wire VSYNC_I, // Frame boundary pulse
    input wire [15:0] DAC_DATA_I, // Palette DAC inputs to analyzer
    output reg [7:0] RDATA_O, // Read data
    output reg ZERO_WAIT_N_O, // Zero-wait indication, active low
    output reg DISPLAY_CLAIM_O, // Display memory claimed
    output reg EXPANSION_BIOS_ROM_O, // Expansion ROM claimed
    output reg DEBUG_OUT_ZERO_O, // Debug output zero
    output reg DEBUG_OUT_ONE_O, // Debug output one
    output reg RAS_N_O, // DRAM row strobe, active low
    output reg CAS_N_O, // DRAM column strobe, active low
    output reg CAS_EXTEND_O, // Adds d, 2d or half delay on CAS low; off for field code 3
    output reg [1:0] CAS_EXTEND_SEL_O, // 1 = d, 2 = 2d
    output reg RAS_EXTEND_O, // Adds d to RAS precharge
    output reg [15:0] SIGNATURE_O, // Current signature
    output reg SIG_BUSY_O // Signature in progress
);
    // --------------------------------------------------------
    // Registers
    // --------------------------------------------------------
    reg [7:0] dram_timing_q; // dram_timing_control
    reg [3:0] map_q; // display_memory_map low nibble
    reg [5:0] dbg_sel_q; // debug_output_select
    reg [3:0] sig_ctrl_q; // signature_analyzer_control low bits
    reg [7:0] tim_live_q; // Timing copy used by the sequencer
    reg [15:0] sig_q; // Signature shift register
    reg start_prev_q; // Start bit, last cycle
    reg armed_q; // Waiting for frame start
    reg busy_q; // Frame being signed
    reg [4:0] state_q; // DRAM sequencer state
    reg [3:0] half_q; // Half-clock phase counter
    reg [4:0] state_d;
    reg [3:0] half_d;
    wire unlocked = (UNLOCK_KEY_I == `UNLOCK_VALUE); // [R12]
    wire sig_rd_en = unlocked && sig_ctrl_q[3];
    wire dbg_en = PIN_CONFIG_I[`PIN_DBG_EN_A] && PIN_CONFIG_I[`PIN_DBG_EN_B]; // [R9]
    wire [15:0] sig_in = sig_ctrl_q[2] ? 16'h0000 : DAC_DATA_I; // [R16]
    wire fb = sig_q[15];

    localparam S_IDLE = 5'h01;
    localparam S_RAS = 5'h02;
    localparam S_CASL = 5'h04;
    localparam S_CASH = 5'h08;
    localparam S_PRE = 5'h10;

    // --------------------------------------------------------
    // Register writes
    // --------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            dram_timing_q <= `RST_DRAM_TIMING;
            map_q <= 4'h0; // [R8]
            dbg_sel_q <= 6'h00;
            sig_ctrl_q <= 4'h0;
        end else if (WRITE_I) begin
            case (INDEX_I)
                `IDX_DRAM_TIMING: dram_timing_q <= WDATA_I;
                `IDX_DISP_MAP: map_q <= WDATA_I[3:0];
                `IDX_DEBUG_SEL: dbg_sel_q <= WDATA_I[5:0];
                `IDX_SIG_CTRL: begin
                    // Locked writes are dropped silently
                    if (unlocked) begin
                        sig_ctrl_q <= WDATA_I[3:0]; // [R12]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // Read mux and decode, registered
    // --------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            RDATA_O <= `RST_BYTE_ZERO;
            DISPLAY_CLAIM_O <= 1'b0;
            EXPANSION_BIOS_ROM_O <= 1'b0;
        end else begin
            case (INDEX_I)
                `IDX_DRAM_TIMING: RDATA_O <= dram_timing_q;
                `IDX_DISP_MAP: RDATA_O <= {4'h0, map_q};
                `IDX_DEBUG_SEL: RDATA_O <= {2'h0, dbg_sel_q};
                // Upper bits read zero; locked reads return zero
                `IDX_SIG_CTRL: RDATA_O <= unlocked ? {4'h0, sig_ctrl_q} : `RST_BYTE_ZERO;
                `IDX_SIG_LOW: RDATA_O <= sig_rd_en ? sig_q[7:0] : `RST_BYTE_ZERO;
                `IDX_SIG_HIGH: RDATA_O <= sig_rd_en ? sig_q[15:8] : `RST_BYTE_ZERO;
                default: RDATA_O <= `RST_BYTE_ZERO;
            endcase
            DISPLAY_CLAIM_O <= MEM_ACCESS_I && (HOST_ADDR_UPPER_NIBBLE_I == map_q); // [R6]
            EXPANSION_BIOS_ROM_O <= ROM_ACCESS_I && (HOST_ADDR_UPPER_NIBBLE_I == 4'h0); // [R7]
        end
    end

    // --------------------------------------------------------
    // Zero-wait and debug outputs
    // --------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ZERO_WAIT_N_O <= 1'b1;
            DEBUG_OUT_ZERO_O <= 1'b0;
            DEBUG_OUT_ONE_O <= 1'b0;
        end else begin
            // Code 00 is never asserted; it is left idle high
            case (dram_timing_q[7:6])
                `ZW_WBUF: ZERO_WAIT_N_O <= ~(WBUF_READY_I && MEM_DECODED_I); // [R1]
                `ZW_WBUF_MWR: ZERO_WAIT_N_O <=
                    ~(WBUF_READY_I && MEM_DECODED_I && !MEM_WRITE_STROBE_N_I); // [R1]
                `ZW_WBUF_MWR_IO: ZERO_WAIT_N_O <=
                    ~((WBUF_READY_I && MEM_DECODED_I && !MEM_WRITE_STROBE_N_I)
                      || IO_WRITE_I); // [R1]
                default: ZERO_WAIT_N_O <= 1'b1; // [R2]
            endcase
            if (!dbg_en) begin
                // Mux is inert until both pin-config bits are set
                DEBUG_OUT_ZERO_O <= 1'b0; // [R9]
                DEBUG_OUT_ONE_O <= 1'b0;
            end else begin
                case (dbg_sel_q[5:3])
                    3'h0: DEBUG_OUT_ONE_O <= FONT_FETCH_I; // [R10]
                    3'h1: DEBUG_OUT_ONE_O <= GFX_FETCH_I;
                    3'h2: DEBUG_OUT_ONE_O <= WBUF_READY_I;
                    3'h3: DEBUG_OUT_ONE_O <= CPU_WRITE_I;
                    3'h4: DEBUG_OUT_ONE_O <= ~WRITE_BYPASS_I;
                    default: DEBUG_OUT_ONE_O <= 1'b0;
                endcase
                case (dbg_sel_q[2:0])
                    3'h0: DEBUG_OUT_ZERO_O <= IO_DECODED_I; // [R11]
                    3'h1: DEBUG_OUT_ZERO_O <= ATTR_FETCH_I;
                    3'h2: DEBUG_OUT_ZERO_O <= WBUF_EMPTY_I;
                    3'h3: DEBUG_OUT_ZERO_O <= CPU_READ_I;
                    3'h4: DEBUG_OUT_ZERO_O <= ~WBUF_CYCLE_I;
                    default: DEBUG_OUT_ZERO_O <= 1'b0;
                endcase
            end
        end
    end

    // --------------------------------------------------------
    // DRAM sequencer, counted in half clocks (two phases per cycle)
    // --------------------------------------------------------
    always @* begin
        state_d = state_q;
        half_d = half_q + 4'h2;
        case (state_q)
            S_IDLE: begin
                half_d = 4'h0;
                if (DRAM_REQ_I) begin
                    state_d = S_RAS;
                end
            end
            S_RAS: begin
                // Both the 2.5- and 1.5-clock starts round up onto the whole-clock grid
                if (half_q + 4'h2 >= (tim_live_q[2] ? `CAS_START_EARLY : `CAS_START_LATE)) begin
                    state_d = S_CASL; // [R4]
                    half_d = 4'h0;
                end
            end
            S_CASL: begin
                state_d = S_CASH; // [R3]
            end
            S_CASH: begin
                state_d = S_PRE;
                half_d = 4'h0;
            end
            S_PRE: begin
                // The idle cycle that follows keeps RAS high too, so leave one clock early
                case (tim_live_q[1:0]) // [R5]
                    `RP_3: if (half_q + 4'h4 >= `PRE_HALVES_3) state_d = S_IDLE;
                    `RP_2: if (half_q + 4'h4 >= `PRE_HALVES_2) state_d = S_IDLE;
                    default: if (half_q + 4'h4 >= `PRE_HALVES_25) state_d = S_IDLE;
                endcase
            end
            default: state_d = S_IDLE;
        endcase
    end

    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            state_q <= S_IDLE;
            half_q <= 4'h0;
            tim_live_q <= `RST_DRAM_TIMING;
            RAS_N_O <= 1'b1;
            CAS_N_O <= 1'b1;
            CAS_EXTEND_O <= 1'b0;
            CAS_EXTEND_SEL_O <= 2'h0;
            RAS_EXTEND_O <= 1'b0;
        end else begin
            state_q <= state_d;
            half_q <= half_d;
            // Latch new timing only between accesses
            if (state_q == S_IDLE) begin
                tim_live_q <= dram_timing_q; // [R17]
            end
            RAS_N_O <= !(state_d == S_RAS || state_d == S_CASL || state_d == S_CASH);
            CAS_N_O <= !(state_d == S_CASL); // [R3]
            CAS_EXTEND_O <= (state_d == S_CASL) && (tim_live_q[4:3] != 2'h3);
            CAS_EXTEND_SEL_O <= (tim_live_q[4:3] == `CAS_D2) ? 2'h2 :
                                (tim_live_q[4:3] == `CAS_HALF) ? 2'h3 : 2'h1;
            RAS_EXTEND_O <= (state_d == S_PRE) && (tim_live_q[1:0] == `RP_25D); // [R5]
        end
    end

    // --------------------------------------------------------
    // Signature analyzer control and shift register
    // --------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            sig_q <= `RST_SIG;
            start_prev_q <= 1'b0;
            armed_q <= 1'b0;
            busy_q <= 1'b0;
            SIGNATURE_O <= `RST_SIG;
            SIG_BUSY_O <= 1'b0;
        end else begin
            start_prev_q <= sig_ctrl_q[0];
            if (!sig_ctrl_q[1]) begin
                sig_q <= `SIG_PRELOAD; // [R15]
                armed_q <= 1'b0;
                busy_q <= 1'b0;
            end else begin
                // Only a fresh 0-to-1 start arms a new run
                if (sig_ctrl_q[0] && !start_prev_q) begin
                    armed_q <= 1'b1; // [R14]
                end else if (armed_q && VSYNC_I) begin
                    armed_q <= 1'b0;
                    busy_q <= 1'b1;
                end else if (busy_q && VSYNC_I) begin
                    busy_q <= 1'b0; // [R14]
                end
                if (busy_q) begin
                    sig_q <= ({sig_q[14:0], 1'b0} ^ (fb ? `SIG_POLY : 16'h0000)) ^ sig_in;
                end
            end
            SIGNATURE_O <= sig_q;
            SIG_BUSY_O <= busy_q || armed_q;
        end
    end
endmodule // ext_config_dram_debug_sig_regs

// file: ext_cfg_map.vh
// Purpose: Offsets, field positions, codes and reset values of the extended config bank
// Assumes: Indexed access through a sequencer-style index/data pair
// Notes:   Definitions only
`ifndef EXT_CFG_MAP_VH
`define EXT_CFG_MAP_VH
// ------------------------------------------------------------
// Register indexes
// ------------------------------------------------------------
`define IDX_UNLOCK_KEY 8'h06
`define IDX_DRAM_TIMING 8'h13
`define IDX_DISP_MAP 8'h14
`define IDX_DEBUG_SEL 8'h15
`define IDX_SIG_CTRL 8'h16
`define IDX_SIG_LOW 8'h17
`define IDX_SIG_HIGH 8'h18
`define UNLOCK_VALUE 8'h48
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_DRAM_TIMING 8'hc0
`define RST_BYTE_ZERO 8'h00
`define RST_SIG 16'h0001
`define SIG_PRELOAD 16'h0001
`define SIG_POLY 16'h8016
// ------------------------------------------------------------
// Field codes
// ------------------------------------------------------------
`define ZW_WBUF 2'h1
`define ZW_WBUF_MWR 2'h2
`define ZW_WBUF_MWR_IO 2'h3
`define CAS_D1 2'h0
`define CAS_D2 2'h1
`define CAS_HALF 2'h2
`define RP_25D 2'h0
`define RP_3 2'h1
`define RP_2 2'h2
`define RP_25 2'h3
// Half-cycle phase counts (CAS start 2.5 or 1.5 clocks, precharge widths)
`define CAS_START_LATE 4'h5
`define CAS_START_EARLY 4'h3
`define CAS_HALVES 4'h4
`define PRE_HALVES_2 4'h4
`define PRE_HALVES_25 4'h5
`define PRE_HALVES_3 4'h6
`define PIN_DBG_EN_A 5
`define PIN_DBG_EN_B 3
`endif

// file: ext_cfg_host_model.sv
// Purpose: Host side model that reaches the bank by index and data
// Assumes: Drives on the falling edge of the memory clock
// Notes:   Keeps the software obligations of the bank
`timescale 1ns/10ps
`include "ext_cfg_map.vh"
module ext_cfg_host_model (
    input wire CLOCK_I, // Memory clock
    input wire [7:0] RDATA_I, // Read data
    output reg [7:0] INDEX_O, // Index
    output reg [7:0] WDATA_O, // Write data
    output reg WRITE_O, // Write strobe
    output reg [7:0] KEY_O // Unlock key level
);
    initial begin
        {INDEX_O, WDATA_O, WRITE_O, KEY_O} = 25'h0;
    end
    // Write one byte; reserved codes and bits are never sent
    task wr(input [7:0] idx, input [7:0] d);
        reg [7:0] v;
        begin
            v = d;
            if (idx == `IDX_DRAM_TIMING && v[7:6] == 2'h0) v[7:6] = 2'h3;
            if (idx == `IDX_SIG_CTRL) v[7:4] = 4'h0;
            @(negedge CLOCK_I);
            INDEX_O = idx;
            WDATA_O = v;
            WRITE_O = 1'b1;
            @(negedge CLOCK_I);
            WRITE_O = 1'b0;
        end
    endtask
    // Read path is registered, so hold the index two edges
    task rd(input [7:0] idx, output [7:0] d);
        begin
            @(negedge CLOCK_I);
            INDEX_O = idx;
            repeat (2) @(negedge CLOCK_I);
            d = RDATA_I;
        end
    endtask
    // Key must be loaded before the signature control is touched
    task key(input [7:0] k);
        begin
            @(negedge CLOCK_I);
            KEY_O = k;
        end
    endtask
endmodule // ext_cfg_host_model

// file: ext_cfg_regs_props.sv
// Purpose: Port-level checker for the extended config bank
// Assumes: Bench never rewrites DRAM timing while a cycle runs
// Notes:   Shadows the timing byte and mapping nibble from host writes
`timescale 1ns/10ps
`include "ext_cfg_map.vh"
module ext_cfg_regs_props (
    input wire CLOCK_I, // Clock
    input wire RESET_I, // Reset
    input wire [7:0] INDEX_I, // Index
    input wire [7:0] WDATA_I, // Write data
    input wire WRITE_I, // Write strobe
    input wire [7:0] PIN_CONFIG_I, // Pin config
    input wire WBUF_READY_I, // Buffer ready
    input wire MEM_DECODED_I, // Decoded
    input wire MEM_WRITE_STROBE_N_I, // Write strobe
    input wire IO_WRITE_I, // I/O write
    input wire [3:0] HOST_ADDR_UPPER_NIBBLE_I, // Address 23:20
    input wire MEM_ACCESS_I, // Memory cycle
    input wire ROM_ACCESS_I, // ROM cycle
    input wire ZERO_WAIT_N_O, // Zero wait
    input wire DISPLAY_CLAIM_O, // Claim
    input wire EXPANSION_BIOS_ROM_O, // ROM claim
    input wire DEBUG_OUT_ZERO_O, // Debug 0
    input wire DEBUG_OUT_ONE_O, // Debug 1
    input wire RAS_N_O, // RAS
    input wire CAS_N_O, // CAS
    input wire [15:0] SIGNATURE_O // Signature
);
    default clocking dc @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    reg [7:0] tim_q; // Timing byte shadow
    reg [3:0] map_q; // Mapping nibble shadow
    wire zw_a = WBUF_READY_I && MEM_DECODED_I;
    wire zw_b = zw_a && !MEM_WRITE_STROBE_N_I;
    wire zw_on = (tim_q[7:6] == `ZW_WBUF) ? zw_a : (tim_q[7:6] == `ZW_WBUF_MWR) ? zw_b :
        (tim_q[7:6] == `ZW_WBUF_MWR_IO) ? (zw_b || IO_WRITE_I) : 1'b0;
    // Shadow registers follow host writes on the same edge as the bank
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            tim_q <= `RST_DRAM_TIMING;
            map_q <= 4'h0;
        end else if (WRITE_I) begin
            if (INDEX_I == `IDX_DRAM_TIMING) tim_q <= WDATA_I;
            if (INDEX_I == `IDX_DISP_MAP) map_q <= WDATA_I[3:0];
        end
    end
    AST_ZERO_WAIT: assert property (!$past(RESET_I) |-> ZERO_WAIT_N_O == !$past(zw_on))
        else $error("zero-wait output wrong");
    AST_CAS_LATE: assert property ($fell(RAS_N_O) && !tim_q[2] |-> CAS_N_O[*3] ##1 !CAS_N_O)
        else $error("late CAS start wrong");
    AST_CAS_EARLY: assert property ($fell(RAS_N_O) && tim_q[2] |-> CAS_N_O[*2] ##1 !CAS_N_O)
        else $error("early CAS start wrong");
    AST_CAS_LOW: assert property ($fell(CAS_N_O) |=> CAS_N_O)
        else $error("CAS low width wrong");
    AST_PRE_LONG: assert property ($rose(RAS_N_O) && tim_q[1:0] != `RP_2 |-> RAS_N_O[*3])
        else $error("long precharge too short");
    AST_PRE_SHORT: assert property ($rose(RAS_N_O) |-> RAS_N_O[*2])
        else $error("short precharge too short");
    AST_CLAIM: assert property (!$past(RESET_I) |->
        DISPLAY_CLAIM_O == $past(MEM_ACCESS_I && HOST_ADDR_UPPER_NIBBLE_I == map_q))
        else $error("display claim wrong");
    AST_ROM: assert property (!$past(RESET_I) |->
        EXPANSION_BIOS_ROM_O == $past(ROM_ACCESS_I && HOST_ADDR_UPPER_NIBBLE_I == 4'h0))
        else $error("ROM claim wrong");
    AST_DBG_GATE: assert property (!(PIN_CONFIG_I[5] && PIN_CONFIG_I[3]) |=>
        !DEBUG_OUT_ZERO_O && !DEBUG_OUT_ONE_O)
        else $error("debug pins not gated");
    AST_RESET_STATE: assert property ($past(RESET_I) && $past(RESET_I, 2) |->
        !DISPLAY_CLAIM_O && RAS_N_O && CAS_N_O && SIGNATURE_O == `RST_SIG)
        else $error("reset state wrong");
    cover property ($fell(CAS_N_O));
    cover property (DISPLAY_CLAIM_O);
    cover property (DEBUG_OUT_ONE_O);
endmodule // ext_cfg_regs_props
bind ext_config_dram_debug_sig_regs ext_cfg_regs_props u_props (.CLOCK_I(CLOCK_I),
    .RESET_I(RESET_I), .INDEX_I(INDEX_I), .WDATA_I(WDATA_I), .WRITE_I(WRITE_I),
    .PIN_CONFIG_I(PIN_CONFIG_I), .WBUF_READY_I(WBUF_READY_I), .MEM_DECODED_I(MEM_DECODED_I),
    .MEM_WRITE_STROBE_N_I(MEM_WRITE_STROBE_N_I), .IO_WRITE_I(IO_WRITE_I),
    .HOST_ADDR_UPPER_NIBBLE_I(HOST_ADDR_UPPER_NIBBLE_I), .MEM_ACCESS_I(MEM_ACCESS_I),
    .ROM_ACCESS_I(ROM_ACCESS_I), .ZERO_WAIT_N_O(ZERO_WAIT_N_O),
    .DISPLAY_CLAIM_O(DISPLAY_CLAIM_O), .EXPANSION_BIOS_ROM_O(EXPANSION_BIOS_ROM_O),
    .DEBUG_OUT_ZERO_O(DEBUG_OUT_ZERO_O), .DEBUG_OUT_ONE_O(DEBUG_OUT_ONE_O),
    .RAS_N_O(RAS_N_O), .CAS_N_O(CAS_N_O), .SIGNATURE_O(SIGNATURE_O));

// file: ext_config_dram_debug_sig_regs_bench.sv
// Purpose: Self-checking bench for the extended config bank
// Assumes: Inputs change on the falling edge
// Notes:   Expected values follow the field tables
`timescale 1ns/10ps
`include "ext_cfg_map.vh"
module ext_config_dram_debug_sig_regs_bench;
    localparam [19:0] SRC1 = {4'd6, 4'd5, 4'd0, 4'd8, 4'd7}; // Sources of output one
    localparam [19:0] SRC0 = {4'd2, 4'd4, 4'd1, 4'd9, 4'd3}; // Sources of output zero
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [9:0] st = 10'h0; // Status levels
    reg [5:0] ctl = 6'h01; // req rom mem dec iowr strobe_n
    reg [3:0] nib = 4'h0;
    reg vs = 1'b0;
    reg [7:0] pin = 8'h00;
    reg [15:0] dac = 16'h0;
    reg [7:0] r, t;
    reg [15:0] s1;
    integer bad_count = 0;
    integer total_checks = 0;
    integer i, n;
    wire [7:0] idx, wd, key, rdata;
    wire wr, zw_n, claim, rom, d0, d1, ras_n, cas_n, busy, cext, rext;
    wire [1:0] csel;
    wire [15:0] sig;
    always #10 clk = ~clk;
    ext_cfg_host_model h (.CLOCK_I(clk), .RDATA_I(rdata), .INDEX_O(idx), .WDATA_O(wd),
        .WRITE_O(wr), .KEY_O(key));
    ext_config_dram_debug_sig_regs u_dut (.CLOCK_I(clk), .RESET_I(rst), .INDEX_I(idx),
        .WDATA_I(wd), .WRITE_I(wr), .UNLOCK_KEY_I(key), .PIN_CONFIG_I(pin),
        .WBUF_READY_I(st[0]), .WBUF_EMPTY_I(st[1]), .WBUF_CYCLE_I(st[2]),
        .MEM_DECODED_I(ctl[2]), .MEM_WRITE_STROBE_N_I(ctl[0]), .IO_WRITE_I(ctl[1]),
        .IO_DECODED_I(st[3]), .CPU_READ_I(st[4]), .CPU_WRITE_I(st[5]),
        .WRITE_BYPASS_I(st[6]), .FONT_FETCH_I(st[7]), .GFX_FETCH_I(st[8]),
        .ATTR_FETCH_I(st[9]), .HOST_ADDR_UPPER_NIBBLE_I(nib), .MEM_ACCESS_I(ctl[3]),
        .ROM_ACCESS_I(ctl[4]), .DRAM_REQ_I(ctl[5]), .VSYNC_I(vs), .DAC_DATA_I(dac),
        .RDATA_O(rdata), .ZERO_WAIT_N_O(zw_n), .DISPLAY_CLAIM_O(claim),
        .EXPANSION_BIOS_ROM_O(rom), .DEBUG_OUT_ZERO_O(d0), .DEBUG_OUT_ONE_O(d1),
        .RAS_N_O(ras_n), .CAS_N_O(cas_n), .CAS_EXTEND_O(cext), .CAS_EXTEND_SEL_O(csel),
        .RAS_EXTEND_O(rext), .SIGNATURE_O(sig), .SIG_BUSY_O(busy));
    task wrap_up;
        begin
            $display("checks=%0d mismatches=%0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Bounded wait on RAS (0), CAS (1) or busy (2); n holds the cycles spent
    task wait_lvl(input integer w, input v);
        begin
            n = 0;
            while (((w == 0) ? ras_n : (w == 1) ? cas_n : busy) !== v && n < 200) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n == 200) begin
                chk(16'h0, 16'h1);
                wrap_up;
            end
        end
    endtask
    task t_regs;
        begin
            h.rd(`IDX_DRAM_TIMING, r);
            chk(r, `RST_DRAM_TIMING);
            h.rd(`IDX_DISP_MAP, r);
            chk(r, `RST_BYTE_ZERO);
            h.wr(`IDX_DISP_MAP, 8'hf5);
            h.rd(`IDX_DISP_MAP, r);
            chk(r, 8'h05);
            h.rd(8'h30, r);
            chk(r, 8'h00);
            for (i = 0; i < 16; i = i + 5) begin
                @(negedge clk);
                nib = i[3:0];
                ctl[4:3] = 2'h3;
                @(negedge clk);
                chk(claim, i == 5);
                chk(rom, i == 0);
            end
            ctl[4:3] = 2'h0;
            // Reset again mid-run: the written nibble must drop back to zero
            @(negedge clk);
            rst = 1'b1;
            repeat (2) @(negedge clk);
            rst = 1'b0;
            h.rd(`IDX_DISP_MAP, r);
            chk(r, `RST_BYTE_ZERO);
            $display("register and decode test done");
        end
    endtask
    task t_dbg;
        begin
            pin = 8'h28;
            for (i = 0; i < 16; i = i + 1) begin
                h.wr(`IDX_DEBUG_SEL, {2'h0, i[3:1], i[3:1]});
                st = {10{~i[0]}};
                if (i < 10) st[SRC1[i[3:1] * 4 +: 4]] = i[0];
                if (i < 10) st[SRC0[i[3:1] * 4 +: 4]] = i[0];
                repeat (2) @(negedge clk);
                chk({d1, d0}, (i < 8) ? {2{i[0]}} : (i < 10) ? {2{~i[0]}} : 2'h0);
            end
            h.wr(`IDX_DEBUG_SEL, 8'h00);
            st = 10'h3ff;
            pin = 8'h20;
            repeat (2) @(negedge clk);
            chk({d1, d0}, 2'h0);
            $display("debug mux test done");
        end
    endtask
    task t_zw;
        begin
            st[0] = 1'b1;
            for (i = 1; i < 4; i = i + 1) begin
                h.wr(`IDX_DRAM_TIMING, {i[1:0], 6'h00});
                ctl[2:0] = 3'h4;
                repeat (2) @(negedge clk);
                chk(zw_n, 1'b0);
                ctl[2:0] = 3'h7;
                repeat (2) @(negedge clk);
                chk(zw_n, i == 2);
            end
            ctl[2:0] = 3'h1;
            $display("zero-wait test done");
        end
    endtask
    task t_dram;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                t = {2'h3, 6'h00};
                t[4:3] = i % 3;
                t[2] = i[0];
                t[1:0] = i[2:1];
                h.wr(`IDX_DRAM_TIMING, t);
                ctl[5] = 1'b1;
                wait_lvl(0, 1'b0);
                wait_lvl(1, 1'b0);
                chk(n, t[2] ? 2 : 3);
                chk(csel, t[4:3] + 2'h1);
                chk(cext, 1'b1);
                wait_lvl(1, 1'b1);
                chk(n, 1);
                wait_lvl(0, 1'b1);
                chk(rext, t[1:0] == `RP_25D);
                wait_lvl(0, 1'b0);
                chk(n, (t[1:0] == `RP_2) ? 2 : 3);
                ctl[5] = 1'b0;
                wait_lvl(0, 1'b1);
                repeat (6) @(negedge clk);
            end
            $display("DRAM timing test done");
        end
    endtask
    task t_sig;
        begin
            h.wr(`IDX_SIG_CTRL, 8'h07);
            h.rd(`IDX_SIG_CTRL, r);
            chk(r, 8'h00);
            h.key(`UNLOCK_VALUE);
            h.wr(`IDX_SIG_CTRL, 8'h00);
            repeat (2) @(negedge clk);
            chk(sig, `SIG_PRELOAD);
            for (i = 0; i < 2; i = i + 1) begin
                dac = i ? 16'h1234 : 16'hffff;
                h.wr(`IDX_SIG_CTRL, 8'h04);
                h.wr(`IDX_SIG_CTRL, 8'h06);
                h.wr(`IDX_SIG_CTRL, 8'h07);
                h.rd(`IDX_SIG_CTRL, r);
                chk(r, 8'h07);
                chk(sig, `SIG_PRELOAD);
                repeat (2) @(negedge clk) vs = ~vs;
                wait_lvl(2, 1'b1);
                repeat (2) @(negedge clk) vs = ~vs;
                wait_lvl(2, 1'b0);
                @(negedge clk);
                chk(sig == `SIG_PRELOAD, 1'b0);
                if (i == 0) s1 = sig;
                if (i == 1) chk(sig, s1);
            end
            $display("signature test done");
        end
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_regs;
        t_dbg;
        t_zw;
        t_dram;
        t_sig;
        wrap_up;
    end
endmodule // ext_config_dram_debug_sig_regs_bench
